// File: rtl/qbs_defs.svh
// Constants for the burst SRAM port protocol block.
// Assumes nothing; included by its bare name.
`ifndef QBS_DEFS_SVH
`define QBS_DEFS_SVH

// Word and byte lane layout
`define QBS_WORD_W        18
`define QBS_LANES         2
`define QBS_LANE_W        9
`define QBS_LANE0_LSB     0
`define QBS_LANE1_LSB     9
`define QBS_ADDR_W        19
`define QBS_BURST_LEN     4

// Burst timing in input clock edges counted from the start edge
`define QBS_WR_FIRST_EDGE 2
`define QBS_RD_FIRST_PLL  5
`define QBS_RD_FIRST_LEG  2

// Clock and PLL timing
`define QBS_CLK_PERIOD_NS 20
`define QBS_PLL_LOCK_US   100
`define QBS_PLL_STOP_NS   30

// Reset values
`define QBS_RST_OE        1'b0
`define QBS_RST_DATA      18'h00000

`endif

// File: rtl/qbs_pkg.sv
// Types shared by the burst SRAM port protocol block.
// Assumes the constants header is on the include path.
`include "qbs_defs.svh"

package qbs_pkg;

    // Input clock edge strobes, one clk cycle each
    typedef struct packed {
        logic k_rise;
        logic kn_rise;
    } qbs_edge_t;

    // Active-low port selects sampled on K rises
    typedef struct packed {
        logic read_port_select_n;
        logic write_port_select_n;
    } qbs_sel_t;

    // Write data word with its byte write selects
    typedef struct packed {
        logic [`QBS_WORD_W-1:0] data;
        logic [`QBS_LANES-1:0]  byte_write_select_n;
    } qbs_wr_t;

    // Kind of a burst tracker slot
    typedef enum logic {
        QBS_SLOT_RD,
        QBS_SLOT_WR
    } qbs_slot_kind_t;

endpackage

// File: rtl/qbs_mem.sv
// Flip-flop storage array with per-lane write masks and write forwarding.
// Assumes one write and one read index per clk cycle.
`timescale 1ns/100ps
`include "qbs_defs.svh"

module qbs_mem #(
    parameter int AW    = `QBS_ADDR_W,
    parameter int LANES = `QBS_LANES,
    parameter int LW    = `QBS_LANE_W
) (
    input  wire logic                clk,
    input  wire logic                we,
    input  wire logic [AW-1:0]       waddr,
    input  wire logic [LANES*LW-1:0] wdata,
    input  wire logic [LANES-1:0]    wmask_n,
    input  wire logic [AW-1:0]       raddr,
    output logic      [LANES*LW-1:0] rdata
);

    ////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [LW-1:0] arr      [2**AW];
            logic [LW-1:0] next_arr [2**AW];
            logic          lane_we;

            // Lane written only when its select is low
            assign lane_we = we & ~wmask_n[g];

            // Next contents of the lane
            always_comb begin
                next_arr = arr;
                if (lane_we) begin
                    next_arr[waddr] = wdata[g*LW +: LW];
                end
            end

            // Register the lane
            always_ff @(posedge clk) begin
                arr <= next_arr;
            end

            // Newest data wins on a same-index hit
            assign rdata[g*LW +: LW] = (lane_we && waddr == raddr) ?
                wdata[g*LW +: LW] : arr[raddr];
        end
    endgenerate

endmodule

// File: rtl/qbs_pll.sv
// Lock tracker for the device PLL.
// Assumes edge strobes are synchronous to clk.
`timescale 1ns/100ps
`include "qbs_defs.svh"

module qbs_pll #(
    parameter int unsigned LOCK_CYC = 5000,
    parameter int unsigned STOP_CYC = 2
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic enable,
    input  wire logic clk_seen,
    output logic      locked
);

    localparam int CW = $clog2(LOCK_CYC + 1);
    localparam int IW = $clog2(STOP_CYC + 1);

    logic [CW-1:0] lock_cnt;
    logic [CW-1:0] next_lock_cnt;
    logic [IW-1:0] idle_cnt;
    logic [IW-1:0] next_idle_cnt;
    logic          next_locked;

    ////////////////////////////////////////////////////////////////////
    // Lock after a stable clock, lose lock on a stop or slowdown
    always_comb begin
        next_lock_cnt = lock_cnt;
        next_idle_cnt = idle_cnt;
        next_locked   = locked;
        if (!enable) begin
            next_lock_cnt = '0;
            next_idle_cnt = '0;
            next_locked   = 1'b0;
        end else if (clk_seen) begin
            next_idle_cnt = '0;
            if (lock_cnt < CW'(LOCK_CYC)) begin
                next_lock_cnt = lock_cnt + CW'(1);
            end else begin
                next_locked = 1'b1;
            end
        end else if (idle_cnt + IW'(1) >= IW'(STOP_CYC)) begin
            next_idle_cnt = IW'(STOP_CYC);
            next_lock_cnt = '0;
            next_locked   = 1'b0;
        end else begin
            next_idle_cnt = idle_cnt + IW'(1);
        end
    end

    // Register lock state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_cnt <= '0;
            idle_cnt <= '0;
            locked   <= 1'b0;
        end else if (ce) begin
            lock_cnt <= next_lock_cnt;
            idle_cnt <= next_idle_cnt;
            locked   <= next_locked;
        end
    end

endmodule

// File: rtl/qbs_top.sv
// Port protocol of a burst-of-four SRAM with separate read and write ports.
// Assumes K and K-bar rises arrive as one-cycle strobes synchronous to clk.
`timescale 1ns/100ps
`include "qbs_defs.svh"

module qbs_top #(
    parameter int          AW       = `QBS_ADDR_W,
    parameter int unsigned LOCK_CYC = (`QBS_PLL_LOCK_US * 1000) /
                                      `QBS_CLK_PERIOD_NS
) (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   ce,
    input  wire qbs_pkg::qbs_edge_t     k_edge,
    input  wire qbs_pkg::qbs_sel_t      port_sel,
    input  wire logic [AW-1:0]          addr,
    input  wire qbs_pkg::qbs_wr_t       wr_in,
    input  wire logic                   pll_enable_pin,
    input  wire logic                   termination_range_select,
    output logic [`QBS_WORD_W-1:0]      rd_data,
    output logic                        rd_oe,
    output logic                        pll_locked,
    output logic                        odt_high_range
);
    import qbs_pkg::*;

    localparam int          NSLOT    = 4;
    localparam int unsigned STOP_CYC = (`QBS_PLL_STOP_NS +
        `QBS_CLK_PERIOD_NS - 1) / `QBS_CLK_PERIOD_NS;
    localparam logic [3:0]  WR_FIRST = 4'(`QBS_WR_FIRST_EDGE);
    localparam logic [3:0]  RD_PLL   = 4'(`QBS_RD_FIRST_PLL);
    localparam logic [3:0]  RD_LEG   = 4'(`QBS_RD_FIRST_LEG);
    localparam logic [3:0]  LAST_OFS = 4'(`QBS_BURST_LEN - 1);

    logic          k_r;
    logic          kn_r;
    logic          any_edge;
    logic          rd_req;
    logic          wr_req;
    logic          start_rd;
    logic          start_wr;
    logic          prev_rd;
    logic          prev_wr;
    logic          next_prev_rd;
    logic          next_prev_wr;
    logic          rd_ptr;
    logic          wr_ptr;
    logic          next_rd_ptr;
    logic          next_wr_ptr;
    logic [NSLOT-1:0] fire;
    logic [AW-1:0] word_addr [NSLOT];
    logic          rd_fire;
    logic          wr_fire;
    logic [AW-1:0] rd_addr;
    logic [AW-1:0] wr_addr;
    logic [`QBS_WORD_W-1:0] mem_rdata;
    logic [`QBS_WORD_W-1:0] next_rd_data;
    logic          next_rd_oe;
    logic          odt_done;
    logic          next_odt_done;
    logic          next_odt_high_range;

    ////////////////////////////////////////////////////////////////////
    // Edge qualifiers; no edges while the clocks stand still
    assign k_r      = ce & k_edge.k_rise;
    assign kn_r     = ce & k_edge.kn_rise & ~k_edge.k_rise;
    assign any_edge = k_r | kn_r;

    ////////////////////////////////////////////////////////////////////
    // Command decode and arbitration on K rises
    always_comb begin
        rd_req   = k_r & ~port_sel.read_port_select_n & ~prev_rd;
        wr_req   = k_r & ~port_sel.write_port_select_n & ~prev_wr;
        start_rd = rd_req;
        start_wr = wr_req & ~rd_req;
        next_prev_rd = prev_rd;
        next_prev_wr = prev_wr;
        next_rd_ptr  = rd_ptr ^ start_rd;
        next_wr_ptr  = wr_ptr ^ start_wr;
        if (k_r) begin
            next_prev_rd = start_rd;
            next_prev_wr = start_wr;
        end
    end

    // Register arbitration history and slot pointers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_rd <= 1'b0;
            prev_wr <= 1'b0;
            rd_ptr  <= 1'b0;
            wr_ptr  <= 1'b0;
        end else if (ce) begin
            prev_rd <= next_prev_rd;
            prev_wr <= next_prev_wr;
            rd_ptr  <= next_rd_ptr;
            wr_ptr  <= next_wr_ptr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Burst trackers: slots 0 and 1 read, slots 2 and 3 write
    genvar s;
    generate
        for (s = 0; s < NSLOT; s++) begin : g_slot
            localparam qbs_slot_kind_t KIND = (s < 2) ? QBS_SLOT_RD :
                                                        QBS_SLOT_WR;
            logic          act;
            logic          next_act;
            logic [3:0]    cnt;
            logic [3:0]    next_cnt;
            logic [3:0]    first;
            logic [3:0]    next_first;
            logic [AW-1:0] base;
            logic [AW-1:0] next_base;
            logic [3:0]    ncnt;
            logic [3:0]    ofs;
            logic          mine;

            assign mine = (KIND == QBS_SLOT_RD) ?
                (start_rd && rd_ptr == 1'(s)) :
                (start_wr && wr_ptr == 1'(s - 2));
            assign ncnt = cnt + 4'h1;
            assign ofs  = ncnt - first;
            assign fire[s] = act & any_edge & (ncnt >= first) &
                             (ofs <= LAST_OFS);
            assign word_addr[s] = base + AW'(ofs[1:0]);

            // Next slot state
            always_comb begin
                next_act   = act;
                next_cnt   = cnt;
                next_first = first;
                next_base  = base;
                if (act && any_edge) begin
                    next_cnt = ncnt;
                    if (fire[s] && ofs == LAST_OFS) begin
                        next_act = 1'b0;
                    end
                end
                if (mine) begin
                    next_act  = 1'b1;
                    next_cnt  = 4'h0;
                    next_base = addr;
                    if (KIND == QBS_SLOT_WR) begin
                        next_first = WR_FIRST;
                    end else if (pll_enable_pin) begin
                        next_first = RD_PLL;
                    end else begin
                        next_first = RD_LEG;
                    end
                end
            end

            // Register slot state
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    act   <= 1'b0;
                    cnt   <= 4'h0;
                    first <= 4'h0;
                    base  <= '0;
                end else if (ce) begin
                    act   <= next_act;
                    cnt   <= next_cnt;
                    first <= next_first;
                    base  <= next_base;
                end
            end
        end
    endgenerate

    // Port-side launch and capture selection
    assign rd_fire = fire[0] | fire[1];
    assign wr_fire = fire[2] | fire[3];
    assign rd_addr = fire[0] ? word_addr[0] : word_addr[1];
    assign wr_addr = fire[2] ? word_addr[2] : word_addr[3];

    ////////////////////////////////////////////////////////////////////
    // Storage; selects come with each word
    qbs_mem #(
        .AW    (AW),
        .LANES (`QBS_LANES),
        .LW    (`QBS_LANE_W)
    ) u_mem (
        .clk     (clk),
        .we      (wr_fire),
        .waddr   (wr_addr),
        .wdata   (wr_in.data),
        .wmask_n (wr_in.byte_write_select_n),
        .raddr   (rd_addr),
        .rdata   (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // Read output launch and tri-state control
    always_comb begin
        next_rd_data = rd_data;
        next_rd_oe   = rd_oe;
        if (rd_fire) begin
            next_rd_data = mem_rdata;
            next_rd_oe   = 1'b1;
        end else if (kn_r) begin
            next_rd_oe = 1'b0;
        end
    end

    // Register read outputs; frozen while clocks stop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= `QBS_RST_DATA;
            rd_oe   <= `QBS_RST_OE;
        end else if (ce) begin
            rd_data <= next_rd_data;
            rd_oe   <= next_rd_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Termination range caught once after reset release
    always_comb begin
        next_odt_done       = 1'b1;
        next_odt_high_range = odt_high_range;
        if (!odt_done) begin
            next_odt_high_range = termination_range_select;
        end
    end

    // Register termination choice; high range until caught
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            odt_done       <= 1'b0;
            odt_high_range <= 1'b1;
        end else if (ce) begin
            odt_done       <= next_odt_done;
            odt_high_range <= next_odt_high_range;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // PLL lock tracking
    qbs_pll #(
        .LOCK_CYC (LOCK_CYC),
        .STOP_CYC (STOP_CYC)
    ) u_pll (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .enable   (pll_enable_pin),
        .clk_seen (k_edge.k_rise | k_edge.kn_rise),
        .locked   (pll_locked)
    );

endmodule

// File: dv/qbs_host.sv
// Host clock model for the burst SRAM port block.
// Assumes the bench drives selects, address and write data itself.
`timescale 1ns/100ps
`include "qbs_defs.svh"

module qbs_host (
    input  wire logic           clk,
    input  wire logic           sys_rst,
    input  wire logic           run,
    output qbs_pkg::qbs_edge_t  k_edge
);
    import qbs_pkg::*;

    logic phase;

    // K and K-bar rises alternate, one per clk; none while stopped
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase  <= 1'b0;
            k_edge <= '0;
        end else if (run) begin
            phase  <= !phase;
            k_edge <= {!phase, phase};
        end else begin
            k_edge <= '0;
        end
    end
endmodule

// File: dv/qbs_top_chk.sv
// Port checker for the burst SRAM port block.
// Assumes it is bound to qbs_top and sees only its ports.
`timescale 1ns/100ps
`include "qbs_defs.svh"

module qbs_top_chk #(
    parameter int          AW       = 4,
    parameter int unsigned LOCK_CYC = 8
) (
    input wire logic                   clk,
    input wire logic                   sys_rst,
    input wire logic                   ce,
    input wire qbs_pkg::qbs_edge_t     k_edge,
    input wire qbs_pkg::qbs_sel_t      port_sel,
    input wire logic                   pll_enable_pin,
    input wire logic [`QBS_WORD_W-1:0] rd_data,
    input wire logic                   rd_oe,
    input wire logic                   pll_locked,
    input wire logic                   odt_high_range
);
    import qbs_pkg::*;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic        st;
    logic        q1;
    logic        seen;
    int unsigned n_ed;

    assign st = k_edge.k_rise | k_edge.kn_rise;

    // Edge cycles counted toward lock, cleared by a stop or PLL off
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q1   <= 1'b0;
            seen <= 1'b0;
            n_ed <= 0;
        end else if (ce) begin
            q1   <= !st;
            seen <= 1'b1;
            if (!pll_enable_pin || (!st && q1)) begin
                n_ed <= 0;
            end else if (st) begin
                n_ed <= n_ed + 1;
            end
        end
    end

    sequence s_quiet;
        ce && !st ##1 ce && !st;
    endsequence
    sequence s_read_start_pll;
        $past(!port_sel.read_port_select_n && k_edge.k_rise, 6);
    endsequence
    sequence s_read_start_leg;
        $past(!port_sel.read_port_select_n && k_edge.k_rise, 3);
    endsequence

    property p_rst_idle;
        disable iff (1'b0) sys_rst |-> !rd_oe && !pll_locked;
    endproperty
    property p_odt_hold;
        seen |=> $stable(odt_high_range);
    endproperty
    property p_pll_off;
        ce && !pll_enable_pin |=> !pll_locked;
    endproperty
    property p_pll_stop;
        s_quiet |=> !pll_locked;
    endproperty
    property p_freeze;
        !ce |=> $stable(rd_data) && $stable(rd_oe) && $stable(pll_locked);
    endproperty
    property p_stopped_hold;
        ce && !st |=> $stable(rd_data) && $stable(rd_oe);
    endproperty
    property p_lock_min;
        $rose(pll_locked) |-> n_ed >= LOCK_CYC;
    endproperty
    property p_oe_burst;
        $rose(rd_oe) |-> rd_oe [*4];
    endproperty
    property p_oe_cause;
        $rose(rd_oe) |-> s_read_start_pll or s_read_start_leg;
    endproperty

    a_rst_idle:     assert property (p_rst_idle) else $error("busy in reset");
    a_odt_hold:     assert property (p_odt_hold) else $error("range moved");
    a_pll_off:      assert property (p_pll_off) else $error("lock while off");
    a_pll_stop:     assert property (p_pll_stop) else $error("lock kept");
    a_freeze:       assert property (p_freeze) else $error("moved while held");
    a_stopped_hold: assert property (p_stopped_hold) else $error("no edge");
    a_lock_min:     assert property (p_lock_min) else $error("early lock");
    a_oe_burst:     assert property (p_oe_burst) else $error("short burst");
    a_oe_cause:     assert property (p_oe_cause) else $error("stray drive");
endmodule

// File: dv/tb_qbs_top.sv
// Self-checking bench for the burst SRAM port block.
// Assumes the host model makes alternating K and K-bar strobes.
`timescale 1ns/100ps
`include "qbs_defs.svh"

module tb_qbs_top;
    import qbs_pkg::*;

    logic        clk = 1'b0;
    logic        sys_rst = 1'b0;
    logic        ce = 1'b1;
    logic        run = 1'b1;
    logic        pll_enable_pin = 1'b1;
    logic        termination_range_select = 1'b0;
    qbs_edge_t   k_edge;
    qbs_sel_t    port_sel = 2'b11;
    logic [3:0]  addr = 4'h0;
    qbs_wr_t     wr_in = '0;
    logic [17:0] rd_data;
    logic        rd_oe;
    logic        pll_locked;
    logic        odt_high_range;
    logic [17:0] shadow [16];
    int          n_fail = 0;
    int          checks_done = 0;
    int          cyc = 0;

    qbs_host qbs_host_i (.clk(clk), .sys_rst(sys_rst), .run(run),
                         .k_edge(k_edge));
    qbs_top #(.AW(4), .LOCK_CYC(8)) qbs_top_i (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .k_edge(k_edge),
        .port_sel(port_sel), .addr(addr), .wr_in(wr_in),
        .pll_enable_pin(pll_enable_pin),
        .termination_range_select(termination_range_select),
        .rd_data(rd_data), .rd_oe(rd_oe), .pll_locked(pll_locked),
        .odt_high_range(odt_high_range));

    // 50 MHz clock
    always #10 clk = ~clk;

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One clk cycle of inputs, outputs sampled mid-cycle
    task automatic step(input logic rn, wn, input logic [3:0] a,
                        input logic [17:0] w, input logic [1:0] m);
        @(posedge clk);
        port_sel <= {rn, wn};
        addr <= a;
        wr_in <= {w, m};
        @(negedge clk);
    endtask

    // Write at c0, read of same start at c2; dup repeats both too soon
    task automatic burst(input logic [3:0] a, input logic [7:0] m,
                         input logic [17:0] base, input logic pll, dup);
        logic [17:0] d [14];
        logic        o [14];
        logic [1:0]  mk;
        int          fv;
        @(posedge clk);
        pll_enable_pin <= pll;
        do @(negedge clk); while (k_edge.kn_rise !== 1'b1);
        for (int c = 0; c < 14; c++) begin
            mk = (c >= 2 && c <= 5) ? m[2*(c-2)+:2] : 2'b00;
            step(!(c == 2 || (dup && c == 4)), !(c == 0 || (dup && c == 2)),
                 a, base + 18'(c), mk);
            d[c] = rd_data;
            o[c] = rd_oe;
            for (int i = 0; i < 2; i++)
                if (c >= 2 && c <= 5 && !mk[i])
                    shadow[4'(a + c - 2)][9*i+:9] =
                        9'((base + 18'(c)) >> (9*i));
        end
        fv = pll ? 8 : 5;
        check(o[fv-1], 1'b0);
        for (int k = 0; k < 4; k++) begin
            check(o[fv+k], 1'b1);
            check(d[fv+k], shadow[4'(a + k)]);
        end
        check(o[pll ? 12 : 10], 1'b0);
    endtask

    task automatic t_reset();
        repeat (2) @(negedge clk);
        check(odt_high_range, 1'b0);
        check(rd_oe, 1'b0);
        @(posedge clk);
        termination_range_select <= 1'b1;
        repeat (3) @(negedge clk);
        check(odt_high_range, 1'b0);
    endtask

    task automatic t_pll();
        logic [17:0] hold;
        @(posedge clk);
        pll_enable_pin <= 1'b0;
        repeat (2) @(negedge clk);
        check(pll_locked, 1'b0);
        @(posedge clk);
        pll_enable_pin <= 1'b1;
        repeat (5) @(negedge clk);
        check(pll_locked, 1'b0);
        repeat (8) @(negedge clk);
        check(pll_locked, 1'b1);
        hold = rd_data;
        @(posedge clk);
        run <= 1'b0;
        repeat (4) @(negedge clk);
        check(pll_locked, 1'b0);
        check(rd_data, hold);
        @(posedge clk);
        run <= 1'b1;
        ce <= 1'b0;
        repeat (20) @(negedge clk);
        check(pll_locked, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        repeat (13) @(negedge clk);
        check(pll_locked, 1'b1);
    endtask

    // Second reset in mid-run: range pin now high is caught afresh
    task automatic t_rerange();
        @(posedge clk);
        sys_rst <= 1'b1;
        @(negedge clk);
        check(rd_oe, 1'b0);
        check(pll_locked, 1'b0);
        check(odt_high_range, 1'b1);
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(negedge clk);
        check(odt_high_range, 1'b1);
        check(rd_oe, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        sys_rst <= 1'b1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        burst(4'hE, 8'h00, 18'h01000, 1'b1, 1'b0);
        burst(4'hE, 8'b11_10_01_00, 18'h20000, 1'b1, 1'b1);
        burst(4'h1, 8'h00, 18'h00300, 1'b0, 1'b1);
        t_pll();
        t_rerange();
        conclude();
    end
endmodule

bind qbs_top qbs_top_chk #(.AW(AW), .LOCK_CYC(LOCK_CYC)) qbs_top_chk_i (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .k_edge(k_edge),
    .port_sel(port_sel), .pll_enable_pin(pll_enable_pin),
    .rd_data(rd_data), .rd_oe(rd_oe), .pll_locked(pll_locked),
    .odt_high_range(odt_high_range));
